// ### vcm_pkg.sv
// shared constants for the video clock mux control block
package vcm_pkg;
   localparam int          AXI_ADDR_W       = 12;
   localparam int          AXI_DATA_W       = 32;
   localparam int          CTRL_W           = 7;
   localparam logic [11:0] CTRL_OFFSET      = 12'h000;
   localparam logic [6:0]  CTRL_RESET       = 7'h00;
   localparam int          SRC_LSB          = 5;
   localparam int          DAC_GATE_BIT     = 4;
   localparam int          ENC_GATE_BIT     = 3;
   localparam int          INVERT_BIT       = 2;
   localparam int          SEL_LSB          = 0;
   localparam logic [1:0]  SRC_PLL_DIV      = 2'h0;
   localparam logic [1:0]  SRC_XTAL2        = 2'h1;
   localparam logic [1:0]  SRC_XTAL1        = 2'h2;
   localparam logic [1:0]  SEL_REFERENCE    = 2'h0;
   localparam logic [1:0]  SEL_EXTERNAL     = 2'h2;
   localparam logic [1:0]  SEL_PIXEL        = 2'h3;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;
   localparam logic [24:0] UPPER_ZERO       = 25'h0000000;

   typedef enum logic [1:0] {
      VCM_W_IDLE = 2'b01,
      VCM_W_RESP = 2'b10
   } vcm_wstate_e;

   typedef enum logic [1:0] {
      VCM_R_IDLE = 2'b01,
      VCM_R_DATA = 2'b10
   } vcm_rstate_e;
endpackage

// ### vcm_clk_sel.sv
// source selection and gating of the video clocks
`timescale 1ns/1ps
`default_nettype none
module vcm_clk_sel
   import vcm_pkg::*;
(
   input  wire logic       pll_divided_clock,
   input  wire logic       second_crystal_input,
   input  wire logic       first_crystal_input,
   input  wire logic       external_video_clock_pin,
   input  wire logic       pixel_clock_pin,
   input  wire logic [1:0] encoder_ref_source,
   input  wire logic [1:0] video_clock_select,
   input  wire logic       dac_clock_gate,
   input  wire logic       encoder_clock_gate,
   input  wire logic       pixel_clock_invert,
   output logic            ref_clk,
   output logic            video_clk,
   output logic            encoder_clk,
   output logic            dac_clk,
   output logic            capture_pixel_clk
);
   logic pix;
   logic dac_src;

   always_comb begin
      pix = pixel_clock_pin ^ pixel_clock_invert;                 // R4
      unique case (encoder_ref_source)                            // R1
         SRC_PLL_DIV: ref_clk = pll_divided_clock;
         SRC_XTAL2:   ref_clk = second_crystal_input;
         SRC_XTAL1:   ref_clk = first_crystal_input;
         default:     ref_clk = 1'b0;                             // R9
      endcase
      unique case (video_clock_select)
         SEL_REFERENCE: begin
            video_clk = ref_clk;                                  // R5
            dac_src   = ref_clk;                                  // R5
         end
         SEL_EXTERNAL: begin
            video_clk = external_video_clock_pin;                 // R6
            dac_src   = external_video_clock_pin;                 // R6
         end
         SEL_PIXEL: begin
            video_clk = pix;                                      // R7
            dac_src   = 1'b0;                                     // R7
         end
         default: begin
            video_clk = 1'b0;                                     // R9
            dac_src   = 1'b0;                                     // R9
         end
      endcase
      encoder_clk       = video_clk & encoder_clock_gate;         // R3
      dac_clk           = dac_src & dac_clock_gate;               // R2
      capture_pixel_clk = pix;                                    // R4
   end
endmodule // vcm_clk_sel
`default_nettype wire

// ### vcm_top.sv
// video clock mux control: register over axi4-lite and clock selection
//
// What this block does
// R1: encoder reference source field: 0 pll divided, 1 second crystal, 2 first crystal.
// R2: dac clock gate bit passes the dac clock at 1, stops at 0.
// R3: encoder clock gate bit passes the encoder clock at 1, stops at 0.
// R4: invert bit inverts pixel clock to encoder mux and sensor capture controller.
// R5: select 0 uses the chosen reference as video clock and dac clock.
// R6: select 2 uses the external video clock pin for video and dac clock.
// R7: select 3 uses the pixel clock; dac clock held off; 1 reserved.
// R8: control fields reset to zero; bits above source field read zero, ignore writes.
// R9: reserved encodings of either select field give no output clock; the code holds low only the clocks fed by that field, the others keep running.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vcm_top
   import vcm_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [AXI_DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  pll_divided_clock,
   input  wire logic                  second_crystal_input,
   input  wire logic                  first_crystal_input,
   input  wire logic                  external_video_clock_pin,
   input  wire logic                  pixel_clock_pin,
   output logic                       ref_clk_out,
   output logic                       video_clk_out,
   output logic                       encoder_clk_out,
   output logic                       dac_clk_out,
   output logic                       capture_pixel_clk_out
);
   // word decode of the single control register
   function automatic logic is_ctrl(input logic [AXI_ADDR_W-1:0] addr);
      return addr[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2];
   endfunction

   // response code of one access: only the control register is mapped
   function automatic logic [1:0] resp_of(input logic [AXI_ADDR_W-1:0] addr);
      return is_ctrl(addr) ? RESP_OKAY : RESP_SLVERR;
   endfunction

   // ---------------- write channel ----------------
   vcm_wstate_e                 wstate_reg, wstate_next;
   logic                        awready_reg, awready_next;
   logic                        wready_reg, wready_next;
   logic                        bvalid_reg, bvalid_next;
   logic [1:0]                  bresp_reg, bresp_next;
   logic                        aw_have_reg, aw_have_next;
   logic                        w_have_reg, w_have_next;
   logic [AXI_ADDR_W-1:0]       awaddr_reg, awaddr_next;
   logic [AXI_DATA_W-1:0]       wdata_reg, wdata_next;
   logic [3:0]                  wstrb_reg, wstrb_next;
   logic                        wr_fire;
   logic [AXI_ADDR_W-1:0]       wr_addr;
   logic [AXI_DATA_W-1:0]       wr_data;
   logic [3:0]                  wr_strb;

   always_comb begin
      logic aw_take;
      logic w_take;
      logic a_have;
      logic d_have;
      aw_take      = s_axi_awvalid & awready_reg;
      w_take       = s_axi_wvalid & wready_reg;
      a_have       = aw_have_reg | aw_take;
      d_have       = w_have_reg | w_take;
      wr_addr      = aw_take ? s_axi_awaddr : awaddr_reg;
      wr_data      = w_take ? s_axi_wdata : wdata_reg;
      wr_strb      = w_take ? s_axi_wstrb : wstrb_reg;
      wr_fire      = 1'b0;
      wstate_next  = wstate_reg;
      awready_next = awready_reg;
      wready_next  = wready_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      aw_have_next = a_have;
      w_have_next  = d_have;
      awaddr_next  = wr_addr;
      wdata_next   = wr_data;
      wstrb_next   = wr_strb;
      // address and data may come in either order; the write fires once both are held
      unique case (wstate_reg)
         VCM_W_IDLE: begin
            if (a_have && d_have) begin
               wr_fire      = 1'b1;
               wstate_next  = VCM_W_RESP;
               bvalid_next  = 1'b1;
               bresp_next   = resp_of(wr_addr);
               aw_have_next = 1'b0;
               w_have_next  = 1'b0;
               awready_next = 1'b0;
               wready_next  = 1'b0;
            end else begin
               awready_next = ~a_have;
               wready_next  = ~d_have;
            end
         end
         VCM_W_RESP: begin
            if (s_axi_bready) begin
               wstate_next  = VCM_W_IDLE;
               bvalid_next  = 1'b0;
               awready_next = 1'b1;
               wready_next  = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wstate_reg  <= VCM_W_IDLE;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
      end else begin
         wstate_reg  <= wstate_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         awaddr_reg  <= awaddr_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
      end
   end

   // ---------------- control register ----------------
   logic [CTRL_W-1:0] ctrl_reg, ctrl_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      // only byte lane 0 holds stored bits; the rest are dropped
      if (wr_fire && is_ctrl(wr_addr) && wr_strb[0]) begin
         ctrl_next = wr_data[CTRL_W-1:0];                         // R8
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= CTRL_RESET;                                  // R8
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ---------------- read channel ----------------
   vcm_rstate_e           rstate_reg, rstate_next;
   logic                  arready_reg, arready_next;
   logic                  rvalid_reg, rvalid_next;
   logic [1:0]            rresp_reg, rresp_next;
   logic [AXI_DATA_W-1:0] rdata_reg, rdata_next;

   always_comb begin
      rstate_next  = rstate_reg;
      arready_next = arready_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      unique case (rstate_reg)
         VCM_R_IDLE: begin
            arready_next = 1'b1;
            if (s_axi_arvalid && arready_reg) begin
               rstate_next  = VCM_R_DATA;
               arready_next = 1'b0;
               rvalid_next  = 1'b1;
               rresp_next   = resp_of(s_axi_araddr);
               if (is_ctrl(s_axi_araddr)) begin
                  rdata_next = {UPPER_ZERO, ctrl_reg};            // R8
               end else begin
                  rdata_next = '0;
               end
            end
         end
         VCM_R_DATA: begin
            if (s_axi_rready) begin
               rstate_next  = VCM_R_IDLE;
               rvalid_next  = 1'b0;
               arready_next = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstate_reg  <= VCM_R_IDLE;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= '0;
      end else begin
         rstate_reg  <= rstate_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   // ---------------- clock selection ----------------
   logic sel_ref;
   logic sel_video;
   logic sel_encoder;
   logic sel_dac;
   logic sel_capture;

   // control fields as named nets for the clock selector
   logic [1:0] encoder_ref_source;
   logic [1:0] video_clock_select;
   logic       dac_clock_gate;
   logic       encoder_clock_gate;
   logic       pixel_clock_invert;

   assign encoder_ref_source = ctrl_reg[SRC_LSB+1:SRC_LSB];               // R1
   assign video_clock_select = ctrl_reg[SEL_LSB+1:SEL_LSB];               // R5
   assign dac_clock_gate     = ctrl_reg[DAC_GATE_BIT];                    // R2
   assign encoder_clock_gate = ctrl_reg[ENC_GATE_BIT];                    // R3
   assign pixel_clock_invert = ctrl_reg[INVERT_BIT];                      // R4

   // sources are sampled as data on clk, so only sources well below half the
   // clk rate come through intact; this is not a glitch-free clock switch
   vcm_clk_sel u_sel (
      .pll_divided_clock        (pll_divided_clock),
      .second_crystal_input     (second_crystal_input),
      .first_crystal_input      (first_crystal_input),
      .external_video_clock_pin (external_video_clock_pin),
      .pixel_clock_pin          (pixel_clock_pin),
      .encoder_ref_source       (encoder_ref_source),                // R1
      .video_clock_select       (video_clock_select),                // R5
      .dac_clock_gate           (dac_clock_gate),                    // R2
      .encoder_clock_gate       (encoder_clock_gate),                // R3
      .pixel_clock_invert       (pixel_clock_invert),                // R4
      .ref_clk                  (sel_ref),
      .video_clk                (sel_video),
      .encoder_clk              (sel_encoder),
      .dac_clk                  (sel_dac),
      .capture_pixel_clk        (sel_capture)
   );

   logic ref_reg;
   logic video_reg;
   logic encoder_reg;
   logic dac_reg;
   logic capture_reg;

   // sampled copies keep every output on a flop, at the cost of one cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ref_reg     <= 1'b0;
         video_reg   <= 1'b0;
         encoder_reg <= 1'b0;
         dac_reg     <= 1'b0;
         capture_reg <= 1'b0;
      end else begin
         ref_reg     <= sel_ref;
         video_reg   <= sel_video;
         encoder_reg <= sel_encoder;
         dac_reg     <= sel_dac;
         capture_reg <= sel_capture;
      end
   end

   assign ref_clk_out           = ref_reg;
   assign video_clk_out         = video_reg;
   assign encoder_clk_out       = encoder_reg;
   assign dac_clk_out           = dac_reg;
   assign capture_pixel_clk_out = capture_reg;
endmodule // vcm_top
`default_nettype wire

// ### vcm_top_chk.sv
// assertions on the ports of the video clock mux control block
`timescale 1ns/1ps
`default_nettype none
module vcm_top_chk
   import vcm_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0]            s_axi_wstrb,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic                  pll_divided_clock,
   input wire logic                  second_crystal_input,
   input wire logic                  first_crystal_input,
   input wire logic                  external_video_clock_pin,
   input wire logic                  pixel_clock_pin,
   input wire logic                  ref_clk_out,
   input wire logic                  video_clk_out,
   input wire logic                  encoder_clk_out,
   input wire logic                  dac_clk_out,
   input wire logic                  capture_pixel_clk_out
);
   logic [6:0] shad_reg, shad_next;
   logic [7:0] wd_reg, wd_next;
   logic [4:0] exp_reg, exp_next;
   logic       bv_reg, ok_reg, rf, vd, dc, px, chk;
   // shadow of the control register, taken when an okay write response rises for a write that strobed byte lane 0
   assign wd_next = (s_axi_wvalid && s_axi_wready) ? {s_axi_wstrb[0], s_axi_wdata[6:0]} : wd_reg;
   assign shad_next = (s_axi_bvalid && !bv_reg && s_axi_bresp == RESP_OKAY && wd_reg[7]) ? wd_reg[6:0] : shad_reg;
   assign px = pixel_clock_pin ^ shad_reg[INVERT_BIT];
   assign rf = shad_reg[6:5] == SRC_PLL_DIV ? pll_divided_clock : shad_reg[6:5] == SRC_XTAL2 ? second_crystal_input :
               shad_reg[6:5] == SRC_XTAL1 ? first_crystal_input : 1'b0;
   assign vd = shad_reg[1:0] == SEL_REFERENCE ? rf : shad_reg[1:0] == SEL_EXTERNAL ? external_video_clock_pin :
               shad_reg[1:0] == SEL_PIXEL ? px : 1'b0;
   assign dc = shad_reg[1:0] == SEL_REFERENCE ? rf : shad_reg[1:0] == SEL_EXTERNAL ? external_video_clock_pin : 1'b0;
   assign exp_next = {rf, vd, vd & shad_reg[ENC_GATE_BIT], dc & shad_reg[DAC_GATE_BIT], px};
   // clock compares skip the first edge after reset and the edges around a register update
   assign chk = ok_reg && !bv_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shad_reg <= 7'h00;
         wd_reg <= 8'h00;
         exp_reg <= 5'h00;
         bv_reg <= 1'b0;
         ok_reg <= 1'b0;
      end else begin
         shad_reg <= shad_next;
         wd_reg <= wd_next;
         exp_reg <= exp_next;
         bv_reg <= s_axi_bvalid;
         ok_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_ref_source: assert property (chk |-> ref_clk_out == exp_reg[4]) else $error("reference clock wrong");
   a_dac_gate: assert property (chk |-> dac_clk_out == exp_reg[1]) else $error("dac clock wrong");
   a_enc_gate: assert property (chk |-> encoder_clk_out == exp_reg[2]) else $error("encoder clock wrong");
   a_pix_invert: assert property (chk |-> capture_pixel_clk_out == exp_reg[0]) else $error("pixel clock wrong");
   a_video_select: assert property (chk |-> video_clk_out == exp_reg[3])
      else $error("video clock wrong");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == UPPER_ZERO)
      else $error("upper bits set");
   a_rdata_fields: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY && !bv_reg
      |-> s_axi_rdata[6:0] == shad_reg) else $error("read data wrong");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cover property (chk && shad_reg[1:0] == SEL_PIXEL && shad_reg[INVERT_BIT]);
endmodule // vcm_top_chk
bind vcm_top vcm_top_chk u_chk (.*);
`default_nettype wire

// ### test_video_clock_mux_control.sv
// self-checking testbench of the video clock mux control block
`timescale 1ns/1ps
`default_nettype none
module test_video_clock_mux_control
   import vcm_pkg::*;
;
   typedef struct packed {logic [6:0] ctrl; logic [4:0] src; logic [4:0] exp;} vcm_row_s;
   logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]            s_axi_awprot, s_axi_arprot;
   logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
   logic [4:0]            srcs, outs;
   logic pll_divided_clock, second_crystal_input, first_crystal_input, external_video_clock_pin, pixel_clock_pin;
   logic ref_clk_out, video_clk_out, encoder_clk_out, dac_clk_out, capture_pixel_clk_out;
   int   err_total, n_checks;
   // src {pll, xtal2, xtal1, ext, pixel}; exp {ref, video, encoder, dac, capture}
   vcm_row_s rows [14] = '{'{7'h18, 5'b10000, 5'b11110}, '{7'h18, 5'b01111, 5'b00001}, '{7'h38, 5'b01000, 5'b11110},
      '{7'h58, 5'b00100, 5'b11110}, '{7'h78, 5'b11111, 5'b00001}, '{7'h1a, 5'b00010, 5'b01110},
      '{7'h1a, 5'b10101, 5'b10001}, '{7'h1b, 5'b11111, 5'b11101}, '{7'h1f, 5'b00001, 5'b00000},
      '{7'h1f, 5'b00000, 5'b01101}, '{7'h19, 5'b11111, 5'b10001}, '{7'h00, 5'b11111, 5'b11001},
      '{7'h10, 5'b10000, 5'b11010}, '{7'h0e, 5'b00011, 5'b01100}};
   assign {pll_divided_clock, second_crystal_input, first_crystal_input, external_video_clock_pin,
           pixel_clock_pin} = srcs;
   assign outs = {ref_clk_out, video_clk_out, encoder_clk_out, dac_clk_out, capture_pixel_clk_out};
   vcm_top DUT (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) err_total++;
   endtask
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) err_total++;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #80000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      nrst = 1'b0;
      srcs = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wstrb} = '0;
      s_axi_wdata = 32'h00000000;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         axi_write(CTRL_OFFSET, {25'h1ffffff, rows[i].ctrl}, 4'hf, resp);
         check(32'(resp), 32'(RESP_OKAY));
         srcs <= rows[i].src;
         repeat (3) @(posedge clk);
         #1;
         check(32'(outs), 32'(rows[i].exp));
         axi_read(CTRL_OFFSET, rd, resp);
         check(rd, {25'h0000000, rows[i].ctrl});
         check(32'(resp), 32'(RESP_OKAY));
      end
      // unmapped place and a write with its low strobe clear leave the register alone
      axi_write(12'h004, 32'h0000001b, 4'hf, resp);
      check(32'(resp), 32'(RESP_SLVERR));
      axi_read(12'h004, rd, resp);
      check(rd, 32'h00000000);
      check(32'(resp), 32'(RESP_SLVERR));
      axi_write(CTRL_OFFSET, 32'h0000001b, 4'h0, resp);
      check(32'(resp), 32'(RESP_OKAY));
      axi_read(CTRL_OFFSET, rd, resp);
      check(rd, 32'h0000000e);
      srcs <= 5'b11111;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(32'(outs), 32'h00000000);
      @(posedge clk);
      nrst <= 1'b1;
      axi_read(CTRL_OFFSET, rd, resp);
      check(rd, 32'h00000000);
      #1;
      check(32'(outs), 32'h00000019);
      tally_and_finish();
   end
endmodule // test_video_clock_mux_control
`default_nettype wire
